//--- verilog/reset_timer_watchdog.sv
// chip reset sequencer: reset latch, device reset timer and guard timer
// assumes ext pin asynchronous, fuses and wake inputs on mclk_i, one AHB master
// What this block does
// - pin enable fuse selects reset or plain input
// - power-on sets latch, clears reset timer
// - timer counts only with pin high or pin reset function off, then releases
// - core held in reset while timer active
// - reset timer ticks from private oscillator
// - crystal modes use 18 ms period always
// - other modes: 1.125 ms first, then 10 us
// - guard timeout in sleep restarts reset timer
// - reset sources: power, pin, guard, wakes
// - guard timer runs from free oscillator
// - guard timeout or sleep wake resets device
// - guard reset clears timeout flag low
// - guard enable fuse zero disables it
// - 18 ms timeout, prescaler up to 1:128
// - clear instruction resets count and prescaler
// - sleep instruction resets count and prescaler
// - option layout, all ones on reset
// - guard count cleared on any wake
// - power-down flag set on power, cleared sleeping
`default_nettype none
module reset_timer_watchdog
	import reset_timer_pkg::*;
#(
	parameter int unsigned RC_DIV = 1,
	parameter int unsigned HOLD_LONG = HOLD_LONG_CYC,
	parameter int unsigned HOLD_POR_SHORT = HOLD_POR_SHORT_CYC,
	parameter int unsigned GUARD_PERIOD = GUARD_CYC
)
(
	input wire logic mclk_i,
	input wire logic rst_i,
	input wire logic ext_reset_pin_n_i,
	input wire logic reset_pin_enable_cfg_i,
	input wire logic guard_timer_enable_cfg_i,
	input wire logic [2:0] osc_mode_i,
	input wire logic wake_pin_change_i,
	input wire logic wake_comparator_i,
	input wire logic hsel_i,
	input wire logic [31:0] haddr_i,
	input wire logic [1:0] htrans_i,
	input wire logic hwrite_i,
	input wire logic [2:0] hsize_i,
	input wire logic [31:0] hwdata_i,
	input wire logic hready_i,
	output logic [31:0] hrdata_o,
	output logic hreadyout_o,
	output logic hresp_o,
	output logic core_reset_o,
	output logic sleeping_o,
	output logic pin_gpio_o
);
	// parameter sanity
	generate
		if (RC_DIV < 1 || HOLD_LONG < 2 || HOLD_POR_SHORT < 2 || GUARD_PERIOD < 2)
		begin : g_bad
			$error("reset_timer_watchdog: counts out of range");
		end
	endgenerate
	logic pin_meta_reg;
	logic pin_sync_reg;
	seq_state_t state_reg;
	logic [31:0] hold_cnt_reg;
	logic por_pending_reg;
	logic sleeping_reg;
	logic timeout_flag_n_reg;
	logic powerdown_flag_n_reg;
	logic [7:0] option_reg;
	logic [31:0] rc_div_reg;
	logic [6:0] presc_cnt_reg;
	logic [31:0] guard_cnt_reg;
	logic wr_pend_reg;
	logic [7:0] wr_addr_reg;
	logic [31:0] hrdata_reg;
	logic core_reset_reg;
	logic pin_gpio_reg;

	// two-stage synchroniser on the reset pin
	always_ff @(posedge mclk_i)
	begin
		pin_meta_reg <= ext_reset_pin_n_i;
		pin_sync_reg <= pin_meta_reg;
	end

	// pin function and reset source decode
	wire pin_en = reset_pin_enable_cfg_i;
	wire ext_low = pin_en & ~pin_sync_reg;
	wire pin_ok = ~pin_en | pin_sync_reg;
	wire running = (state_reg == SEQ_RUN);
	wire wake_evt = sleeping_reg & (wake_pin_change_i | wake_comparator_i);
	wire guard_fire;
	wire reset_evt = ext_low | guard_fire | wake_evt;

	// bus decode; commands only reach a core that is out of reset
	wire addr_take = hsel_i & htrans_i[1] & hready_i;
	wire wr_now = wr_pend_reg & running;
	wire wr_option = wr_now & (wr_addr_reg == ADDR_OPTION);
	wire wr_cmd = wr_now & (wr_addr_reg == ADDR_CMD);
	wire clear_cmd = wr_cmd & hwdata_i[CMD_CLEAR_BIT];
	wire sleep_cmd = wr_cmd & hwdata_i[CMD_SLEEP_BIT] & ~sleeping_reg;

	// private oscillator tick, free running in and out of sleep
	wire rc_tick = (rc_div_reg == 32'(RC_DIV - 1));
	always_ff @(posedge mclk_i)
	begin
		if (rst_i | rc_tick)
			rc_div_reg <= 32'h0;
		else
			rc_div_reg <= rc_div_reg + 32'h1;
	end

	// reset timer period select by oscillator mode and reset kind
	wire crystal = (osc_mode_i == LOW_POWER_CRYSTAL_MODE) | (osc_mode_i == STD_CRYSTAL_MODE) |
		(osc_mode_i == HIGH_SPEED_CRYSTAL_MODE);
	wire [31:0] hold_period = crystal ? 32'(HOLD_LONG) :
		(por_pending_reg ? 32'(HOLD_POR_SHORT) : HOLD_SHORT_CYC);
	wire hold_last = rc_tick & (hold_cnt_reg == hold_period - 32'h1);

	// reset sequencer next state
	seq_state_t state_next;
	always_comb
	begin
		state_next = state_reg;
		case (state_reg)
			SEQ_HOLD:
				if (pin_ok)
					state_next = SEQ_COUNT;
			SEQ_COUNT:
				if (!pin_ok)
					state_next = SEQ_HOLD;
				else if (hold_last)
					state_next = SEQ_RUN;
			SEQ_RUN:
				if (reset_evt)
					state_next = SEQ_HOLD;
			default:
				state_next = SEQ_HOLD;
		endcase
	end

	// latch and timer; power-on sets the latch and clears the count
	always_ff @(posedge mclk_i)
	begin
		if (rst_i)
			state_reg <= SEQ_HOLD;
		else
			state_reg <= state_next;
	end
	wire hold_clr = rst_i | (state_next != SEQ_COUNT) | (state_reg != SEQ_COUNT);
	always_ff @(posedge mclk_i)
	begin
		if (hold_clr)
			hold_cnt_reg <= 32'h0;
		else if (rc_tick)
			hold_cnt_reg <= hold_cnt_reg + 32'h1;
	end

	// core reset follows the latch and the timer
	always_ff @(posedge mclk_i)
	begin
		if (rst_i)
			core_reset_reg <= 1'b1;
		else
			core_reset_reg <= (state_next != SEQ_RUN);
	end
	// power-on marker picks the longer first period
	always_ff @(posedge mclk_i)
	begin
		if (rst_i)
			por_pending_reg <= 1'b1;
		else if (state_reg == SEQ_COUNT && state_next == SEQ_RUN)
			por_pending_reg <= 1'b0;
	end

	// sleep state; any reset event ends it
	always_ff @(posedge mclk_i)
	begin
		if (rst_i | reset_evt)
			sleeping_reg <= 1'b0;
		else if (sleep_cmd)
			sleeping_reg <= 1'b1;
	end

	// status flags; the guard timeout wins over a simultaneous sleep
	always_ff @(posedge mclk_i)
	begin
		if (rst_i)
			timeout_flag_n_reg <= 1'b1;
		else if (guard_fire)
			timeout_flag_n_reg <= 1'b0;
		else if (sleep_cmd)
			timeout_flag_n_reg <= 1'b1;
	end

	always_ff @(posedge mclk_i)
	begin
		if (rst_i)
			powerdown_flag_n_reg <= 1'b1;
		else if (sleep_cmd)
			powerdown_flag_n_reg <= 1'b0;
	end

	// option register, all ones on every reset
	always_ff @(posedge mclk_i)
	begin
		if (rst_i | reset_evt)
			option_reg <= OPTION_RESET;
		else if (wr_option)
			option_reg <= hwdata_i[7:0];
	end

	// guard timer prescaler: divide by 2 to the rate when assigned
	wire presc_assigned = option_reg[OPT_ASSIGN_BIT];
	wire [OPT_RATE_W-1:0] rate = option_reg[OPT_RATE_LSB +: OPT_RATE_W];
	wire [7:0] presc_span = 8'h1 << rate;
	wire [6:0] presc_limit = 7'(presc_span - 8'h1);
	wire presc_wrap = (presc_cnt_reg == presc_limit);
	wire guard_step = rc_tick & (~presc_assigned | presc_wrap);
	wire guard_on = guard_timer_enable_cfg_i & running;
	wire guard_clr = rst_i | ~guard_on | clear_cmd | sleep_cmd | reset_evt;
	assign guard_fire = guard_on & guard_step &
		(guard_cnt_reg == 32'(GUARD_PERIOD - 1));

	always_ff @(posedge mclk_i)
	begin
		if (guard_clr | ~presc_assigned | (rc_tick & presc_wrap))
			presc_cnt_reg <= 7'h0;
		else if (rc_tick)
			presc_cnt_reg <= presc_cnt_reg + 7'h1;
	end

	always_ff @(posedge mclk_i)
	begin
		if (guard_clr)
			guard_cnt_reg <= 32'h0;
		else if (guard_step)
			guard_cnt_reg <= guard_cnt_reg + 32'h1;
	end

	// pin reads as plain input when its reset function is off
	always_ff @(posedge mclk_i)
	begin
		if (rst_i)
			pin_gpio_reg <= 1'b0;
		else
			pin_gpio_reg <= ~pin_en & pin_sync_reg;
	end

	// read mux; unmapped addresses and the command word read zero
	wire [7:0] rd_addr = haddr_i[7:0];
	wire [31:0] status_word = {27'h0, timeout_flag_n_reg, powerdown_flag_n_reg, 1'b0,
		sleeping_reg, core_reset_reg};
	wire mapped_hi = (haddr_i[31:8] == 24'h0);
	wire [31:0] rd_word = !mapped_hi ? 32'h0 :
		(rd_addr == ADDR_OPTION) ? {24'h0, option_reg} :
		(rd_addr == ADDR_STATUS) ? status_word : 32'h0;

	// zero-wait slave: capture address phase, read data ready for data phase
	always_ff @(posedge mclk_i)
	begin
		if (rst_i)
		begin
			wr_pend_reg <= 1'b0;
			wr_addr_reg <= 8'h0;
			hrdata_reg <= 32'h0;
		end
		else if (hready_i)
		begin
			wr_pend_reg <= addr_take & hwrite_i & mapped_hi;
			wr_addr_reg <= rd_addr;
			hrdata_reg <= (addr_take & ~hwrite_i) ? rd_word : 32'h0;
		end
	end

	assign hrdata_o = hrdata_reg;
	assign hreadyout_o = 1'b1;
	assign hresp_o = 1'b0;
	assign core_reset_o = core_reset_reg;
	assign sleeping_o = sleeping_reg;
	assign pin_gpio_o = pin_gpio_reg;

	// checks
	sequence seq_release;
		state_reg == SEQ_COUNT && pin_ok && hold_last;
	endsequence
	sequence seq_sleep_timeout;
		sleeping_reg && guard_fire;
	endsequence

	AST_PIN_HOLD: assert property (@(posedge mclk_i) disable iff (rst_i)
		ext_low |=> core_reset_o && hold_cnt_reg == 32'h0)
		else $error("low reset pin did not hold reset");
	AST_POR: assert property (@(posedge mclk_i)
		rst_i |=> core_reset_o && state_reg == SEQ_HOLD && por_pending_reg)
		else $error("power-on did not set reset latch");
	AST_PIN_WAIT: assert property (@(posedge mclk_i) disable iff (rst_i)
		state_reg == SEQ_HOLD && !pin_ok |=> state_reg == SEQ_HOLD && hold_cnt_reg == 32'h0)
		else $error("reset timer started with pin low");
	AST_RELEASE: assert property (@(posedge mclk_i) disable iff (rst_i)
		seq_release |=> !core_reset_o && state_reg == SEQ_RUN)
		else $error("reset not released at period end");
	AST_HELD: assert property (@(posedge mclk_i) disable iff (rst_i)
		state_reg == SEQ_COUNT && !hold_last |=> core_reset_o)
		else $error("core left reset while timer active");
	AST_PERIOD_XTAL: assert property (@(posedge mclk_i) disable iff (rst_i)
		crystal |-> hold_period == 32'(HOLD_LONG))
		else $error("crystal mode period wrong");
	AST_PERIOD_FAST: assert property (@(posedge mclk_i) disable iff (rst_i)
		!crystal |-> hold_period == (por_pending_reg ? 32'(HOLD_POR_SHORT) : HOLD_SHORT_CYC))
		else $error("non-crystal mode period wrong");
	AST_SLEEP_WAKE: assert property (@(posedge mclk_i) disable iff (rst_i)
		seq_sleep_timeout |=> state_reg == SEQ_HOLD && !sleeping_o && !timeout_flag_n_reg)
		else $error("sleep timeout did not restart reset timer");
	AST_TIMEOUT: assert property (@(posedge mclk_i) disable iff (rst_i)
		guard_fire |=> core_reset_o ##1 core_reset_o)
		else $error("guard timeout did not reset device");
	AST_TO_FLAG: assert property (@(posedge mclk_i) disable iff (rst_i)
		$fell(timeout_flag_n_reg) |-> $past(guard_fire))
		else $error("timeout flag cleared without timeout");
	AST_GUARD_OFF: assert property (@(posedge mclk_i) disable iff (rst_i)
		!guard_timer_enable_cfg_i |=> guard_cnt_reg == 32'h0 &&
		(timeout_flag_n_reg == $past(timeout_flag_n_reg) || $past(sleep_cmd)))
		else $error("disabled guard timer counted");
	AST_CLEAR: assert property (@(posedge mclk_i) disable iff (rst_i)
		clear_cmd |=> guard_cnt_reg == 32'h0 && presc_cnt_reg == 7'h0)
		else $error("clear instruction left count");
	AST_SLEEP: assert property (@(posedge mclk_i) disable iff (rst_i)
		sleep_cmd && !reset_evt |=> guard_cnt_reg == 32'h0 && !powerdown_flag_n_reg && sleeping_o)
		else $error("sleep instruction mishandled");
	AST_OPTION: assert property (@(posedge mclk_i) disable iff (rst_i)
		reset_evt |=> option_reg == OPTION_RESET)
		else $error("option not reset to ones");
	AST_WAKE: assert property (@(posedge mclk_i) disable iff (rst_i)
		wake_evt |=> guard_cnt_reg == 32'h0 && core_reset_o)
		else $error("wake did not clear guard count");
endmodule
`default_nettype wire

//--- verilog/reset_timer_pkg.sv
// constants shared by the reset sequencer and its guard timer
// assumes a single 100 MHz clock and an AHB-Lite register bus
`default_nettype none
package reset_timer_pkg;
	// clock and timing figures
	localparam real CLK_PERIOD_NS = 10.0;
	localparam real HOLD_LONG_MS = 18.0;
	localparam real HOLD_POR_SHORT_MS = 1.125;
	localparam real HOLD_SHORT_US = 10.0;
	localparam real GUARD_PERIOD_MS = 18.0;
	localparam int HOLD_LONG_CYC = int'(HOLD_LONG_MS * 1.0e6 / CLK_PERIOD_NS);
	localparam int HOLD_POR_SHORT_CYC = int'(HOLD_POR_SHORT_MS * 1.0e6 / CLK_PERIOD_NS);
	localparam logic [31:0] HOLD_SHORT_CYC = 32'(int'(HOLD_SHORT_US * 1.0e3 / CLK_PERIOD_NS));
	localparam int GUARD_CYC = int'(GUARD_PERIOD_MS * 1.0e6 / CLK_PERIOD_NS);
	// register byte addresses
	localparam logic [7:0] ADDR_OPTION = 8'h00;
	localparam logic [7:0] ADDR_CMD = 8'h04;
	localparam logic [7:0] ADDR_STATUS = 8'h08;
	// option register layout
	localparam logic [7:0] OPTION_RESET = 8'hff;
	localparam int OPT_ASSIGN_BIT = 3;
	localparam int OPT_RATE_LSB = 0;
	localparam int OPT_RATE_W = 3;
	// command register bits
	localparam int CMD_CLEAR_BIT = 0;
	localparam int CMD_SLEEP_BIT = 1;
	// status register bits
	localparam int ST_RESET_BIT = 0;
	localparam int ST_SLEEP_BIT = 1;
	localparam int ST_POWERDOWN_BIT = 3;
	localparam int ST_TIMEOUT_BIT = 4;
	// oscillator mode codes from the fuses
	localparam logic [2:0] LOW_POWER_CRYSTAL_MODE = 3'h0;
	localparam logic [2:0] STD_CRYSTAL_MODE = 3'h1;
	localparam logic [2:0] HIGH_SPEED_CRYSTAL_MODE = 3'h2;
	localparam logic [2:0] EXTERNAL_CLOCK_MODE = 3'h3;
	localparam logic [2:0] INTERNAL_OSC_MODE = 3'h4;
	localparam logic [2:0] EXTERNAL_RC_MODE = 3'h5;
	// reset sequencer states
	typedef enum logic [1:0] {SEQ_HOLD, SEQ_COUNT, SEQ_RUN} seq_state_t;
endpackage
`default_nettype wire

//--- dv/ext_pin_model.sv
// board circuitry on the external reset pin: a button against a pull-up
// assumes the bench's clock; press_i high pulls the line low
`default_nettype none
module ext_pin_model
(
	input wire logic mclk_i,
	input wire logic press_i,
	output logic pin_n_o
);
	timeunit 1ns;
	timeprecision 100ps;
	// pull-up holds the line high whenever the button is released
	initial pin_n_o = 1'b1;
	always @(posedge mclk_i)
	begin
		pin_n_o <= ~press_i;
	end
endmodule
`default_nettype wire

//--- dv/tb_top.sv
// self-checking bench for the reset sequencer and guard timer
// assumes short timer parameters and a single AHB-Lite master
`default_nettype none
module tb_top;
	import reset_timer_pkg::*;
	timeunit 1ns;
	timeprecision 100ps;
	logic mclk_i = 1'b0;
	logic rst_i = 1'b1;
	logic press = 1'b0;
	logic pin_en = 1'b1;
	logic guard_en = 1'b1;
	logic wake_pc = 1'b0;
	logic wake_cmp = 1'b0;
	logic [2:0] osc = 3'h0;
	logic hsel = 1'b0;
	logic hwrite = 1'b0;
	logic [1:0] htrans = 2'h0;
	logic [31:0] haddr = 32'h0;
	logic [31:0] hwdata = 32'h0;
	logic [31:0] d;
	wire logic pin_n, hready, hresp, core_rst, slp, gpio;
	wire logic [31:0] hrdata;
	int fail_count = 0;
	int cmp_count = 0;
	// clock, board pin and the block under test
	always #5 mclk_i = ~mclk_i;
	ext_pin_model board (.mclk_i(mclk_i), .press_i(press), .pin_n_o(pin_n));
	reset_timer_watchdog #(.HOLD_LONG(50), .HOLD_POR_SHORT(30), .GUARD_PERIOD(40)) uut (
		.mclk_i(mclk_i), .rst_i(rst_i), .ext_reset_pin_n_i(pin_n),
		.reset_pin_enable_cfg_i(pin_en), .guard_timer_enable_cfg_i(guard_en),
		.osc_mode_i(osc), .wake_pin_change_i(wake_pc), .wake_comparator_i(wake_cmp),
		.hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite),
		.hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hready), .hrdata_o(hrdata),
		.hreadyout_o(hready), .hresp_o(hresp), .core_reset_o(core_rst),
		.sleeping_o(slp), .pin_gpio_o(gpio));
	// closing verdict, shared with the watchdog
	task give_verdict;
		if (fail_count == 0 && cmp_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		cmp_count++;
		if (g !== e)
		begin
			fail_count++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask
	task tick(input int n);
		repeat (n) @(posedge mclk_i);
	endtask
	// power-on with the given fuses, reset held six cycles
	task power(input logic [2:0] m, input logic pe, input logic ge);
		rst_i <= 1'b1;
		osc <= m;
		pin_en <= pe;
		guard_en <= ge;
		tick(6);
		rst_i <= 1'b0;
	endtask
	// one single transfer: address phase, then data phase
	task xfer(input logic w, input logic [7:0] a, input logic [31:0] wd);
		@(posedge mclk_i);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= {24'h0, a};
		do @(posedge mclk_i); while (hready !== 1'b1);
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge mclk_i); while (hready !== 1'b1);
		d = hrdata;
		chk("hresp", 32'h0, {31'h0, hresp});
		hsel <= 1'b0;
		hwrite <= 1'b0;
	endtask
	// waits for core reset to reach v; the wait must lie in [lo,hi]
	task wait_cr(input logic v, input int lo, input int hi);
		int n;
		n = 0;
		while (core_rst !== v && n <= hi)
		begin
			@(posedge mclk_i);
			n++;
		end
		chk("core_reset_delay", 32'h1, {31'h0, n >= lo && n <= hi});
	endtask
	task t_por;
		wait_cr(1'b0, 49, 56);
		xfer(1'b0, ADDR_OPTION, 32'h0);
		chk("option", 32'hff, d);
		xfer(1'b0, ADDR_STATUS, 32'h0);
		chk("status", 32'h18, d & 32'h1b);
		xfer(1'b0, 8'h0c, 32'h0);
		chk("unmapped", 32'h0, d);
	endtask
	task t_guard;
		xfer(1'b1, ADDR_OPTION, 32'h0);
		wait_cr(1'b1, 36, 45);
		xfer(1'b0, ADDR_STATUS, 32'h0);
		chk("status", 32'h09, d & 32'h1b);
		wait_cr(1'b0, 44, 56);
		xfer(1'b0, ADDR_OPTION, 32'h0);
		chk("option", 32'hff, d);
	endtask
	task t_clear;
		xfer(1'b1, ADDR_OPTION, 32'h0);
		repeat (8)
		begin
			tick(15);
			xfer(1'b1, ADDR_CMD, 32'h1);
		end
		chk("core_reset", 32'h0, {31'h0, core_rst});
		xfer(1'b1, ADDR_OPTION, 32'h09);
		wait_cr(1'b1, 70, 90);
		wait_cr(1'b0, 49, 56);
	endtask
	task t_sleep;
		for (int i = 0; i < 2; i++)
		begin
			xfer(1'b1, ADDR_CMD, 32'h2);
			xfer(1'b0, ADDR_STATUS, 32'h0);
			chk("status", 32'h12, d & 32'h1b);
			wake_pc <= (i == 0);
			wake_cmp <= (i == 1);
			tick(1);
			wake_pc <= 1'b0;
			wake_cmp <= 1'b0;
			wait_cr(1'b1, 0, 4);
			chk("sleeping", 32'h0, {31'h0, slp});
			wait_cr(1'b0, 44, 56);
		end
		xfer(1'b1, ADDR_OPTION, 32'h0);
		tick(30);
		xfer(1'b1, ADDR_CMD, 32'h2);
		wait_cr(1'b1, 36, 45);
		xfer(1'b0, ADDR_STATUS, 32'h0);
		chk("status", 32'h01, d & 32'h1b);
		wait_cr(1'b0, 44, 56);
	endtask
	task t_pin;
		press <= 1'b1;
		wait_cr(1'b1, 1, 6);
		tick(20);
		chk("core_reset", 32'h1, {31'h0, core_rst});
		press <= 1'b0;
		wait_cr(1'b0, 50, 58);
	endtask
	task t_fast;
		power(EXTERNAL_CLOCK_MODE, 1'b1, 1'b1);
		wait_cr(1'b0, 29, 36);
		press <= 1'b1;
		wait_cr(1'b1, 1, 6);
		press <= 1'b0;
		wait_cr(1'b0, 1000, 1008);
	endtask
	// the other two crystal codes and the internal oscillator pick their own first period
	task t_modes;
		power(STD_CRYSTAL_MODE, 1'b1, 1'b1);
		wait_cr(1'b0, 49, 56);
		power(HIGH_SPEED_CRYSTAL_MODE, 1'b1, 1'b1);
		wait_cr(1'b0, 49, 56);
		power(INTERNAL_OSC_MODE, 1'b1, 1'b1);
		wait_cr(1'b0, 29, 36);
	endtask
	task t_fuses;
		press <= 1'b1;
		power(EXTERNAL_RC_MODE, 1'b0, 1'b0);
		wait_cr(1'b0, 29, 36);
		chk("pin_gpio", 32'h0, {31'h0, gpio});
		press <= 1'b0;
		tick(5);
		chk("pin_gpio", 32'h1, {31'h0, gpio});
		xfer(1'b1, ADDR_OPTION, 32'h0);
		tick(100);
		chk("core_reset", 32'h0, {31'h0, core_rst});
	endtask
	// main sequence
	initial
	begin
		power(LOW_POWER_CRYSTAL_MODE, 1'b1, 1'b1);
		t_por();
		t_guard();
		t_clear();
		t_sleep();
		t_pin();
		t_fast();
		t_modes();
		t_fuses();
		give_verdict();
	end
	// watchdog against a hang
	initial
	begin
		#100000;
		fail_count++;
		give_verdict();
	end
endmodule
`default_nettype wire
